// *** rtl/stc_map.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * stepper translator and chopper block.
 * Assumes a 50 MHz clock and a byte-addressed AXI4-Lite register window.
 */
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// ==========================================================
// register offsets
`define STC_CTRL_OFS        8'h00
`define STC_CHOP_OFS        8'h04
`define STC_STAT_OFS        8'h08

// ==========================================================
// field positions
`define STC_CTRL_MASTER_BIT 0
`define STC_STAT_POS_LSB    0
`define STC_STAT_LATCH1_BIT 4
`define STC_STAT_LATCH2_BIT 5
`define STC_STAT_HOME_BIT   6
`define STC_STAT_MODE_LSB   8

// ==========================================================
// timing
`define STC_CLK_PERIOD_NS   20
`define STC_CHOP_PERIOD_NS  50000
`define STC_CHOP_CYCLES     (`STC_CHOP_PERIOD_NS / `STC_CLK_PERIOD_NS)

// ==========================================================
// reset values and answers
`define STC_CTRL_RST        32'h0000_0001
`define STC_CHOP_RST        16'(`STC_CHOP_CYCLES)
`define STC_RESP_OKAY       2'h0
`define STC_RESP_SLVERR     2'h2

`endif

// *** rtl/stc_pkg.sv ***
/*
 * Types shared by the stepper translator and chopper block.
 * Assumes stc_map.svh carries every number.
 */
package stc_pkg;

	// ==========================================================
	// drive mode, gray coded along half -> normal -> wave
	typedef enum logic [1:0]
	{
		STC_HALF   = 2'h0,
		STC_NORMAL = 2'h1,
		STC_WAVE   = 2'h3
	} stc_mode_e;

	// ==========================================================
	// lines to the power stage
	typedef struct packed
	{
		logic [3:0] phase_lines;
		logic       inhibit_pair1_n;
		logic       inhibit_pair2_n;
	} stc_drive_s;

endpackage

// *** rtl/stc_translator_chopper.sv ***
/*
 * Stepper phase translator with dual chopper and AXI4-Lite registers.
 * Assumes controller pins and sense comparator outputs are asynchronous,
 * and that the power stage samples the registered drive lines.
 */
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "stc_map.svh"

// Function
// - three sequences chosen by step-size select
// - inhibits driven in half and wave modes
// - chop target select picks phase or inhibit
// - phase chop raises the pair's inactive line
// - oscillator pulse sets both chop latches
// - sense clears latch, drive off until pulse
// - one device drives sync, others follow
// - advance one state per step rising edge in half step, two in full step
// - anticlockwise walks the sequence in reverse
// - reset returns to state one, 0101
// - high step-size select means half step
// - low at odd state gives two-phase-on
// - two-phase-on holds both inhibits high when select is high
// - low at even state gives one-phase-on
// - select low chops inhibits, high chops phases
// - enable low forces all drive lines low
// - home flag active at state one
module stc_translator_chopper
	import stc_pkg::*;
(
	// system
	input  wire logic        clk,
	input  wire logic        rst,
	// controller pins
	input  wire logic        step_pulse_n,
	input  wire logic        rotation_direction,
	input  wire logic        half_full,
	input  wire logic        chop_on_phase,
	input  wire logic        enable,
	input  wire logic        translator_reset_n,
	// sense comparators
	input  wire logic        current_sense_pair1,
	input  wire logic        current_sense_pair2,
	// shared chopper sync pin
	input  wire logic        sync_in,
	output logic             sync_out,
	output logic             sync_oe_n,
	// power stage
	output stc_drive_s       drive,
	output logic             home_flag,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ==========================================================
	// functions
	function automatic logic [3:0] seq_phase(input logic [2:0] pos);
		logic [3:0] p;
		p = 4'h0;
		unique case (pos)
			3'h0: p = 4'h5;
			3'h1: p = 4'h1;
			3'h2: p = 4'h9;
			3'h3: p = 4'h8;
			3'h4: p = 4'hA;
			3'h5: p = 4'h2;
			3'h6: p = 4'h6;
			3'h7: p = 4'h4;
		endcase
		return p;
	endfunction

	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [8:0]  meta_q;
	logic [8:0]  sync_q;
	logic        step_prev_q;
	logic        sync_prev_q;
	logic        step_s, dir_s, half_s, ctrl_s, en_s, treset_n_s, sense1_s, sense2_s;
	logic        sync_s;

	always_ff @(posedge clk)
	begin
		meta_q <= {step_pulse_n, rotation_direction, half_full, chop_on_phase, enable,
			translator_reset_n, current_sense_pair1, current_sense_pair2, sync_in};
		sync_q <= meta_q;
	end

	assign {step_s, dir_s, half_s, ctrl_s, en_s, treset_n_s, sense1_s, sense2_s, sync_s} = sync_q;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			step_prev_q <= 1'b1;
			sync_prev_q <= 1'b0;
		end
		else
		begin
			step_prev_q <= step_s;
			sync_prev_q <= sync_s;
		end
	end

	logic step_rise;
	logic sync_rise;
	assign step_rise = step_s & ~step_prev_q;
	assign sync_rise = sync_s & ~sync_prev_q;

	// ==========================================================
	// registers
	logic        master_q;
	logic [15:0] chop_period_q;

	// ==========================================================
	// translator
	logic [2:0]  pos_q;
	logic [2:0]  step_amt;
	stc_mode_e   mode;

	// full step moves two so the parity picked at selection time holds
	assign step_amt = half_s ? 3'h1 : 3'h2;

	always_ff @(posedge clk)
	begin
		if (rst || !treset_n_s)
			pos_q <= 3'h0;
		else if (step_rise)
			pos_q <= dir_s ? pos_q + step_amt : pos_q - step_amt;
	end

	always_comb
	begin
		if (half_s)
			mode = STC_HALF;
		else if (!pos_q[0])
			mode = STC_NORMAL;
		else
			mode = STC_WAVE;
	end

	// ==========================================================
	// chopper oscillator and latches
	logic [15:0] chop_cnt_q;
	logic        int_pulse;
	logic        chop_pulse;
	logic        sync_out_q;
	logic        latch1_q, latch2_q;

	assign int_pulse  = (chop_cnt_q >= chop_period_q - 16'h1);
	assign chop_pulse = master_q ? int_pulse : sync_rise;

	always_ff @(posedge clk)
	begin
		if (rst || int_pulse)
			chop_cnt_q <= 16'h0;
		else
			chop_cnt_q <= chop_cnt_q + 16'h1;
	end

	// one-cycle pulse; followers need it to pass their two-stage synchroniser
	always_ff @(posedge clk)
	begin
		if (rst)
			sync_out_q <= 1'b0;
		else
			sync_out_q <= master_q & int_pulse;
	end

	assign sync_out  = sync_out_q;
	assign sync_oe_n = ~master_q;

	// set beats a sense trip in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			latch1_q <= 1'b0;
		else if (chop_pulse)
			latch1_q <= 1'b1;
		else if (sense1_s)
			latch1_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			latch2_q <= 1'b0;
		else if (chop_pulse)
			latch2_q <= 1'b1;
		else if (sense2_s)
			latch2_q <= 1'b0;
	end

	// ==========================================================
	// drive lines
	stc_drive_s drive_d;
	stc_drive_s drive_q;
	logic       home_q;
	logic [3:0] seq_now;

	assign seq_now = seq_phase(pos_q);

	always_comb
	begin
		drive_d.phase_lines     = seq_phase(pos_q);
		drive_d.inhibit_pair1_n = (mode == STC_NORMAL) | (|drive_d.phase_lines[3:2]);
		drive_d.inhibit_pair2_n = (mode == STC_NORMAL) | (|drive_d.phase_lines[1:0]);
		if (ctrl_s)
		begin
			// raising the idle line keeps current out of the sense resistor
			if (!latch1_q && ^drive_d.phase_lines[3:2])
				drive_d.phase_lines[3:2] = 2'h3;
			if (!latch2_q && ^drive_d.phase_lines[1:0])
				drive_d.phase_lines[1:0] = 2'h3;
		end
		else
		begin
			drive_d.inhibit_pair1_n = drive_d.inhibit_pair1_n & latch1_q;
			drive_d.inhibit_pair2_n = drive_d.inhibit_pair2_n & latch2_q;
		end
		if (!en_s)
			drive_d = '0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			drive_q <= '0;
			home_q  <= 1'b1;
		end
		else
		begin
			drive_q <= drive_d;
			home_q  <= (pos_q == 3'h0);
		end
	end

	assign drive     = drive_q;
	assign home_flag = home_q;

	// ==========================================================
	// axi4-lite write path
	logic        aw_got_q, w_got_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        aw_have, w_have;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;

	assign s_axi_awready = ~aw_got_q & ~bvalid_q;
	assign s_axi_wready  = ~w_got_q & ~bvalid_q;
	assign aw_have = aw_got_q | (s_axi_awvalid & s_axi_awready);
	assign w_have  = w_got_q | (s_axi_wvalid & s_axi_wready);
	assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
	assign wr_data = w_got_q ? wdata_q : s_axi_wdata;
	assign wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= `STC_RESP_OKAY;
		end
		else if (aw_have && w_have && !bvalid_q)
		begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_addr == `STC_CTRL_OFS || wr_addr == `STC_CHOP_OFS ||
				wr_addr == `STC_STAT_OFS) ? `STC_RESP_OKAY : `STC_RESP_SLVERR;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	logic [31:0] ctrl_word;
	logic [31:0] chop_word;
	assign ctrl_word = {31'h0, master_q};
	assign chop_word = {16'h0, chop_period_q};

	// a function result cannot be bit-selected, so merge into named words first
	logic [31:0] ctrl_merged;
	logic [31:0] chop_merged;
	assign ctrl_merged = merge_bytes(ctrl_word, wr_data, wr_strb);
	assign chop_merged = merge_bytes(chop_word, wr_data, wr_strb);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			master_q      <= 1'(`STC_CTRL_RST);
			chop_period_q <= `STC_CHOP_RST;
		end
		else if (aw_have && w_have && !bvalid_q)
		begin
			if (wr_addr == `STC_CTRL_OFS)
				master_q <= ctrl_merged[`STC_CTRL_MASTER_BIT];
			if (wr_addr == `STC_CHOP_OFS)
				chop_period_q <= chop_merged[15:0];
		end
	end

	// ==========================================================
	// axi4-lite read path
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [31:0] stat_word;

	always_comb
	begin
		stat_word = 32'h0000_0000;
		stat_word[`STC_STAT_POS_LSB +: 3]   = pos_q;
		stat_word[`STC_STAT_LATCH1_BIT]     = latch1_q;
		stat_word[`STC_STAT_LATCH2_BIT]     = latch2_q;
		stat_word[`STC_STAT_HOME_BIT]       = home_q;
		stat_word[`STC_STAT_MODE_LSB +: 2]  = mode;
	end

	assign s_axi_arready = ~rvalid_q;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `STC_RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= `STC_RESP_OKAY;
			unique case (s_axi_araddr)
				`STC_CTRL_OFS: rdata_q <= ctrl_word;
				`STC_CHOP_OFS: rdata_q <= chop_word;
				`STC_STAT_OFS: rdata_q <= stat_word;
				default:
				begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= `STC_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// ==========================================================
	// assertions
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	enable_forces_low_a: assert property (!en_s |=> drive == '0)
		else $error("drive not low while disabled");
	reset_home_a: assert property (!treset_n_s |=> pos_q == 3'h0 ##1 home_flag)
		else $error("translator reset did not reach home");
	half_step_a: assert property (step_rise && half_s && treset_n_s
		|=> pos_q == $past(pos_q) + ($past(dir_s) ? 3'h1 : 3'h7))
		else $error("half step moved wrongly");
	full_step_a: assert property (step_rise && !half_s && treset_n_s
		|=> pos_q[0] == $past(pos_q[0]) && pos_q != $past(pos_q))
		else $error("full step lost parity");
	normal_inhibit_a: assert property (en_s && ctrl_s && mode == STC_NORMAL
		|=> drive.inhibit_pair1_n && drive.inhibit_pair2_n)
		else $error("inhibit dropped in two-phase-on");
	latch_set_a: assert property (chop_pulse |=> latch1_q && latch2_q)
		else $error("chop pulse failed to set latches");
	sense_clear_a: assert property (sense1_s && !chop_pulse |=> !latch1_q)
		else $error("sense trip did not clear latch");
	phase_chop_a: assert property (en_s && ctrl_s && !latch1_q && seq_now[3:2] == 2'h2
		|=> drive.phase_lines[3:2] == 2'h3)
		else $error("inactive phase not raised in chop");
	inhibit_chop_a: assert property (en_s && !ctrl_s && !latch2_q |=> !drive.inhibit_pair2_n)
		else $error("inhibit not chopped");
	wave_inhibit_a: assert property (en_s && ctrl_s && mode == STC_WAVE && latch1_q
		&& seq_now[3:2] == 2'h0 |=> !drive.inhibit_pair1_n)
		else $error("idle pair inhibit not low");
	follower_sync_a: assert property (!master_q && sync_rise |=> latch1_q && latch2_q)
		else $error("follower ignored sync pulse");

	half_cycle_c: cover property (half_s && step_rise && pos_q == 3'h7 ##1 pos_q == 3'h0);
	ccw_step_c: cover property (!dir_s && step_rise);
	phase_chop_c: cover property (ctrl_s && en_s && !latch1_q);
	follower_c: cover property (!master_q && sync_rise);

endmodule

// *** test/stc_bridge_model.sv ***
/*
 * Behavioural power bridge with current sense comparators.
 * Assumes the block's drive struct and a shared clock.
 */
`timescale 1ns/1ps
module stc_bridge_model
	import stc_pkg::*;
#(
	parameter int TRIP_CYCLES = 5
)
(
	// system
	input  wire logic       clk,
	// from the block
	input  wire stc_drive_s drive,
	// comparator trips
	output logic            current_sense_pair1,
	output logic            current_sense_pair2
);
	logic [7:0] rise1_q;
	logic [7:0] rise2_q;

	// ==========================================================
	// current builds only while a pair is driven one way
	always_ff @(posedge clk)
		rise1_q <= (drive.inhibit_pair1_n && ^drive.phase_lines[3:2]) ? rise1_q + 8'h01 : 8'h00;
	always_ff @(posedge clk)
		rise2_q <= (drive.inhibit_pair2_n && ^drive.phase_lines[1:0]) ? rise2_q + 8'h01 : 8'h00;
	assign current_sense_pair1 = (rise1_q >= 8'(TRIP_CYCLES));
	assign current_sense_pair2 = (rise2_q >= 8'(TRIP_CYCLES));
endmodule

// *** test/tb_stc_translator_chopper.sv ***
/*
 * Self-checking bench of the translator and chopper block.
 * Assumes stc_bridge_model stands in for the power stage.
 */
`timescale 1ns/1ps
`include "stc_map.svh"
module tb_stc_translator_chopper
	import stc_pkg::*;
;
	logic        clk, rst, step_pulse_n, rotation_direction, half_full, chop_on_phase;
	logic        enable, translator_reset_n, sync_drv, sync_out, sync_oe_n, home_flag;
	wire logic   current_sense_pair1, current_sense_pair2, sync_in;
	stc_drive_s  drive;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          mismatches, cmp_count, pos, n;
	localparam logic [3:0] TBL [8] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4};

	// the follower side drives the shared pin only when the block lets go
	assign sync_in = sync_oe_n ? sync_drv : sync_out;

	stc_translator_chopper stc_translator_chopper_inst (.clk, .rst, .step_pulse_n,
		.rotation_direction, .half_full, .chop_on_phase, .enable, .translator_reset_n,
		.current_sense_pair1, .current_sense_pair2, .sync_in, .sync_out, .sync_oe_n,
		.drive, .home_flag, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	stc_bridge_model #(.TRIP_CYCLES(5)) stc_bridge_model_inst (.clk, .drive,
		.current_sense_pair1, .current_sense_pair2);

	// ==========================================================
	// clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========================================================
	// helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// handshakes judged on settled values before the edge that takes them
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_go, w_go, b_go;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(negedge clk);
			aw_go = s_axi_awvalid & s_axi_awready;
			w_go = s_axi_wvalid & s_axi_wready;
			b_go = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk);
			if (aw_go)
				s_axi_awvalid <= 1'b0;
			if (w_go)
				s_axi_wvalid <= 1'b0;
		end while (!b_go);
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		logic ar_go, r_go;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(negedge clk);
			ar_go = s_axi_arvalid & s_axi_arready;
			r_go = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk);
			if (ar_go)
				s_axi_arvalid <= 1'b0;
		end while (!r_go);
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	// steps slower than the synchronisers need, then judges the lines
	task automatic walk(input logic dir, input int cnt);
		logic [1:0] inh;
		repeat (cnt)
		begin
			rotation_direction <= dir;
			repeat (3) @(posedge clk);
			step_pulse_n <= 1'b0;
			repeat (3) @(posedge clk);
			step_pulse_n <= 1'b1;
			repeat (8) @(posedge clk);
			pos = (pos + (dir ? 1 : 7) * (half_full ? 1 : 2)) % 8;
			inh = {|TBL[pos][3:2], |TBL[pos][1:0]};
			if (!chop_on_phase)
				check("phase", drive.phase_lines, TBL[pos]);
			else
				check("inhibit", {drive.inhibit_pair1_n, drive.inhibit_pair2_n}, inh);
		end
	endtask

	task automatic wait_drive(input logic [5:0] mask, input logic [5:0] val, input int lim);
		n = 0;
		while ((drive & mask) !== val && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs();
		check("home", home_flag, 1);
		check("idle", drive, 0);
		check("sync_oe_n", sync_oe_n, 0);
		axi_rd(`STC_CTRL_OFS);
		check("ctrl", rd, `STC_CTRL_RST);
		axi_rd(`STC_CHOP_OFS);
		check("chop", rd, 32'(`STC_CHOP_RST));
		axi_rd(8'h0C);
		check("unmapped", {rd[29:0], rsp}, {30'h0, `STC_RESP_SLVERR});
		axi_wr(`STC_STAT_OFS, 32'hFFFF_FFFF);
		check("stat_wr", rsp, `STC_RESP_OKAY);
		axi_rd(`STC_STAT_OFS);
		check("stat", rd, 32'h1 << `STC_STAT_HOME_BIT);
		// short period keeps chop waits brief
		axi_wr(`STC_CHOP_OFS, 32'h14);
		enable <= 1'b1;
	endtask

	task automatic t_modes();
		walk(1'b1, 9);
		walk(1'b0, 3);
		walk(1'b1, 2);
		check("home", home_flag, 1);
		half_full <= 1'b0;
		walk(1'b1, 5);
		axi_rd(`STC_STAT_OFS);
		check("normal", {rd[9:8], rd[2:0]}, {STC_NORMAL, 3'(pos)});
		chop_on_phase <= 1'b1;
		walk(1'b0, 2);
		{chop_on_phase, half_full} <= 2'h1;
		walk(1'b1, 1);
		half_full <= 1'b0;
		walk(1'b1, 4);
		walk(1'b0, 1);
		axi_rd(`STC_STAT_OFS);
		check("wave", {rd[9:8], rd[2:0]}, {STC_WAVE, 3'(pos)});
		{chop_on_phase, half_full} <= 2'h3;
		walk(1'b1, 8);
		walk(1'b1, (10 - pos) % 8);
	endtask

	task automatic t_chop();
		wait_drive(6'h30, 6'h30, 3000);
		check("chop_off", n < 3000, 1);
		wait_drive(6'h30, 6'h20, 3000);
		check("chop_on", n < 3000, 1);
		chop_on_phase <= 1'b0;
		wait_drive(6'h02, 6'h00, 3000);
		check("inh_chop", n < 3000, 1);
		check("phase_kept", drive.phase_lines, 4'h9);
	endtask

	task automatic t_sync();
		chop_on_phase <= 1'b1;
		n = 0;
		while (sync_out !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		check("sync_pulse", n < 3000, 1);
		axi_wr(`STC_CTRL_OFS, 32'h0);
		repeat (100) @(posedge clk);
		check("follower", {sync_oe_n, drive.phase_lines[3:2]}, 3'h7);
		sync_drv <= 1'b1;
		repeat (3) @(posedge clk);
		sync_drv <= 1'b0;
		wait_drive(6'h30, 6'h20, 10);
		check("sync_set", n < 10, 1);
		axi_wr(`STC_CTRL_OFS, 32'h1);
	endtask

	task automatic t_pins();
		enable <= 1'b0;
		repeat (4) @(posedge clk);
		check("disabled", drive, 0);
		{enable, translator_reset_n, chop_on_phase} <= 3'h4;
		repeat (6) @(posedge clk);
		check("trst", {home_flag, drive.phase_lines}, 5'h15);
		translator_reset_n <= 1'b1;
		// settle time before the first step
		repeat (50) @(posedge clk);
		pos = 0;
		walk(1'b1, 1);
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		{rst, step_pulse_n, rotation_direction, half_full, translator_reset_n} = 5'h1F;
		{chop_on_phase, enable, sync_drv} = 3'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		{mismatches, cmp_count, pos} = 96'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_modes();
		t_chop();
		t_sync();
		t_pins();
		print_verdict();
	end

	initial
	begin
		#600000;
		mismatches++;
		print_verdict();
	end
endmodule
